/* File: rtl/scc_pkg.sv */
/*
 * package of the synthesis clock control block: register map, field
 * layouts, reset values, sequencer states, timing counts and carriers.
 * assumes a 50 MHz pclk and a 32-bit APB master.
 */
package scc_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned XO_STARTUP_TIME_US = 500;
   localparam int unsigned SYNTH_LOCK_TIME_US = 150;
   localparam int unsigned SYNTH_LOCK_TYP_US = 80;
   localparam int unsigned XO_STARTUP_CYC = XO_STARTUP_TIME_US * CLK_MHZ;
   localparam int unsigned SYNTH_LOCK_CYC = SYNTH_LOCK_TIME_US * CLK_MHZ;
   localparam int unsigned COARSE_CAL_CYC = 64;
   localparam int unsigned FINE_CAL_CYC = 16;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned FREQ_STEP_SHIFT = 19;

   // ************************************************************
   // register indices; the byte address is four times the index
   // ************************************************************
   localparam logic [7:0] IDX_FRF_MSB = 8'h07;
   localparam logic [7:0] IDX_FRF_MID = 8'h08;
   localparam logic [7:0] IDX_FRF_LSB = 8'h09;
   localparam logic [7:0] IDX_PIN_MAP2 = 8'h26;
   localparam logic [7:0] IDX_CTRL = 8'h40;
   localparam logic [7:0] IDX_STATUS = 8'h41;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h42;
   localparam logic [7:0] IDX_IRQ_EN = 8'h43;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h44;
   localparam logic [7:0] IDX_FRF_LIVE = 8'h45;

   // ************************************************************
   // fields and reset values
   // ************************************************************
   localparam logic [23:0] FRF_RST = 24'h00_0000;
   // ctrl: [0] seq_en [1] pll_on [2] path_tx [3] sleep [5:4] band
   localparam int unsigned CTRL_SEQ = 0;
   localparam int unsigned CTRL_PLL = 1;
   localparam int unsigned CTRL_TX = 2;
   localparam int unsigned CTRL_SLEEP = 3;
   localparam int unsigned CTRL_BAND = 4;
   localparam logic [7:0] CTRL_RST = 8'h01;
   // pin_map_second_reg [2:0] refclk_out_select, [5:4] lock pin select
   localparam int unsigned MAP_LOCK = 4;
   localparam logic [7:0] PIN_MAP2_RST = 8'h00;
   localparam logic [2:0] CLKSEL_OFF = 3'h7;
   // irq bits: [0] xo_ready [1] lock [2] unlock [3] path_started
   localparam int unsigned IRQ_W = 4;
   localparam logic [3:0] IRQ_RST = 4'h0;

   typedef enum logic [2:0] {
      SCC_ST_XO = 3'b000,
      SCC_ST_CAL = 3'b001,
      SCC_ST_IDLE = 3'b010,
      SCC_ST_FINE = 3'b011,
      SCC_ST_LOCK = 3'b100,
      SCC_ST_RUN = 3'b101
   } scc_state_t;

   typedef struct packed {
      logic lock;
      logic xo_stable;
   } scc_ana_in_t;

   typedef struct packed {
      logic [23:0] frf;
      logic pll_en;
      logic rx_en;
      logic tx_en;
      logic [2:0] vco_mult;
   } scc_ana_out_t;

endpackage

/* File: rtl/scc_synth_ctrl.sv */
/*
 * synthesis clock control: carrier word staging, startup sequencer,
 * vco calibration timing, lock indication on pins and reference clock
 * output with divider. assumes xo_stable and pll lock come from analog
 * macros outside this clock domain and are synchronised here.
 */
// The APB slave port was left to the implementer.
// Behaviour
// (R1) carrier is a 24-bit word over three byte addresses, rf = word * step
// (R2) step is crystal frequency over 2^19, constant resolution
// (R3) upper two bytes staged; word takes effect on low byte write
// (R4) sequencer starts pll once crystal is stable
// (R5) reference clock output stays quiet until crystal is stable
// (R6) without sequencer host waits crystal startup or watches clock out
// (R7) reference or a fraction of it drives gpio five, per select field
// (R8) clock output on after reset, in every mode but sleep
// (R9) host disables clock output when not needed
// (R10) sequencer starts rx or tx once pll locked
// (R11) manual host waits lock time or polls lock indicator
// (R12) lock indication high when locked, routable to selected pins
// (R13) lock may drop during wide fm deviation; consumers tolerate
// (R14) coarse calibration once after reset, fine on each pll start
// (R15) vco multiplier 2, 4 or 6 by upper, middle, lower band
// (R16) lock from standby typically 80 us, at most 150 us
// (R17) clock divider select is a small field with an off code
// (R18) sequencer steps xo stable, pll locked, path started in order
`timescale 1ns/1ps
`default_nettype none
module scc_synth_ctrl
   import scc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire scc_pkg::scc_ana_in_t ana_in,
   output scc_pkg::scc_ana_out_t ana_out,
   output logic gpio_five,
   output logic [3:0] gpio_lock,
   output logic pll_lock_indicator,
   output logic irq
);
   import scc_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      // pin synchronisers and settled levels
      logic [2:0] xo_sync;
      logic [2:0] lk_sync;
      logic xo_ok;
      logic lk_ok;
      // carrier staging and live word
      logic [7:0] frf_hi;
      logic [7:0] frf_mid;
      logic [23:0] frf;
      // software registers
      logic [7:0] ctrl;
      logic [7:0] map2;
      logic [3:0] irq_stat;
      logic [3:0] irq_en;
      // sequencer, reference divider and lock pins
      scc_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [6:0] div;
      logic clk_o;
      logic [3:0] lock_pins;
      // bus answer and registered outputs
      logic [31:0] rdata;
      logic ready;
      logic err;
      scc_ana_out_t ana;
      logic irq;
   } scc_regs_t;

   scc_regs_t q, d;

   // ************************************************************
   // helper functions
   // ************************************************************
   function automatic logic [11:0] byte_addr(input logic [7:0] idx);
      byte_addr = {2'b00, idx, 2'b00};
   endfunction

   // level moves only when stages two and three agree
   function automatic logic sync_level(input logic [2:0] stages,
                                       input logic held);
      if (stages[2] == stages[1]) begin
         sync_level = stages[2];
      end else begin
         sync_level = held;
      end
   endfunction

   function automatic logic pll_active(input scc_state_t s);
      pll_active = s == SCC_ST_FINE || s == SCC_ST_LOCK || s == SCC_ST_RUN;
   endfunction

   // select 0 toggles every edge; select n taps bit n, pclk/2^(n+1)
   function automatic logic div_tap(input logic [6:0] cnt_v,
                                    input logic [2:0] sel,
                                    input logic cur);
      if (sel == 3'd0) begin
         div_tap = !cur;
      end else begin
         div_tap = cnt_v[sel];
      end
   endfunction

   // read mux; top bit flags an unmapped address
   function automatic logic [32:0] read_mux(input scc_regs_t s,
                                           input logic [11:0] a);
      logic [31:0] v;
      logic bad;
      v = 32'h0000_0000;
      bad = 1'b0;
      unique case (a)
         byte_addr(IDX_FRF_MSB): begin
            v[7:0] = s.frf_hi;
         end
         byte_addr(IDX_FRF_MID): begin
            v[7:0] = s.frf_mid;
         end
         byte_addr(IDX_FRF_LSB): begin
            v[7:0] = s.frf[7:0];
         end
         byte_addr(IDX_PIN_MAP2): begin
            v[7:0] = s.map2;
         end
         byte_addr(IDX_CTRL): begin
            v[7:0] = s.ctrl;
         end
         // status: lock, crystal, sequencer state
         byte_addr(IDX_STATUS): begin
            v[5:0] = {s.lk_ok, s.xo_ok, 1'b0, s.st};
         end
         byte_addr(IDX_IRQ_STAT): begin
            v[3:0] = s.irq_stat;
         end
         byte_addr(IDX_IRQ_EN): begin
            v[3:0] = s.irq_en;
         end
         // clear register is write only and reads as zero
         byte_addr(IDX_IRQ_CLR): begin
            v = 32'h0000_0000;
         end
         byte_addr(IDX_FRF_LIVE): begin
            v[23:0] = s.frf;
         end
         default: begin
            bad = 1'b1;
         end
      endcase
      read_mux = {bad, v};
   endfunction

   function automatic logic [2:0] band_mult(input logic [1:0] band);
      unique case (band)
         2'b00: band_mult = 3'd2;
         2'b01: band_mult = 3'd4;
         default: band_mult = 3'd6;
      endcase
   endfunction

   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic xo_rise_ev;
   logic lock_ev;
   logic unlock_ev;
   logic start_ev;
   logic [3:0] clr;

   always_comb begin
      d = q;
      setup = psel && !penable;
      access = psel && penable;
      wr = access && pwrite;
      rd = setup && !pwrite;
      clr = 4'h0;
      xo_rise_ev = 1'b0;
      start_ev = 1'b0;

      // ************************************************************
      // pin synchronisers
      // ************************************************************
      d.xo_sync = {q.xo_sync[1:0], ana_in.xo_stable};
      d.lk_sync = {q.lk_sync[1:0], ana_in.lock};
      d.xo_ok = sync_level(q.xo_sync, q.xo_ok);
      d.lk_ok = sync_level(q.lk_sync, q.lk_ok);
      xo_rise_ev = d.xo_ok && !q.xo_ok;
      lock_ev = d.lk_ok && !q.lk_ok;
      unlock_ev = !d.lk_ok && q.lk_ok; // [R13]

      // ************************************************************
      // apb slave: no wait state, answer in the first access cycle
      // ************************************************************
      d.ready = setup;
      d.err = 1'b0;
      if (setup) begin
         {d.err, d.rdata} = read_mux(q, paddr);
         if (pwrite) d.rdata = 32'h0000_0000;
      end
      if (wr && q.ready && !q.err) begin
         unique case (paddr)
            byte_addr(IDX_FRF_MSB): begin
               d.frf_hi = pwdata[7:0]; // [R3]
            end
            byte_addr(IDX_FRF_MID): begin
               d.frf_mid = pwdata[7:0]; // [R3]
            end
            byte_addr(IDX_FRF_LSB): begin
               d.frf = {q.frf_hi, q.frf_mid, pwdata[7:0]}; // [R1] [R3]
            end
            byte_addr(IDX_PIN_MAP2): begin
               d.map2 = pwdata[7:0]; // [R17]
            end
            byte_addr(IDX_CTRL): begin
               d.ctrl = pwdata[7:0];
            end
            byte_addr(IDX_IRQ_EN): begin
               d.irq_en = pwdata[3:0];
            end
            byte_addr(IDX_IRQ_CLR): begin
               clr = pwdata[3:0];
            end
            default: begin
            end
         endcase
      end
      // 'rd' kept for clarity of the setup decode
      if (rd) d.ready = 1'b1;

      // ************************************************************
      // startup sequencer
      // ************************************************************
      if (q.cnt != '0) d.cnt = q.cnt - 1'b1;
      unique case (q.st)
         SCC_ST_XO: begin
            if (q.xo_ok) begin
               d.st = SCC_ST_CAL; // [R18]
               d.cnt = CNT_W'(COARSE_CAL_CYC);
            end
         end
         SCC_ST_CAL: begin
            if (q.cnt == '0) d.st = SCC_ST_IDLE; // [R14] coarse once
         end
         SCC_ST_IDLE: begin
            if (q.ctrl[CTRL_PLL] && !q.ctrl[CTRL_SLEEP] && q.xo_ok) begin
               d.st = SCC_ST_FINE; // [R4] [R14]
               d.cnt = CNT_W'(FINE_CAL_CYC);
            end
         end
         SCC_ST_FINE: begin
            if (q.cnt == '0) begin
               d.st = SCC_ST_LOCK;
               d.cnt = CNT_W'(SYNTH_LOCK_CYC); // [R16]
            end
         end
         SCC_ST_LOCK: begin
            if (q.lk_ok && q.ctrl[CTRL_SEQ]) begin
               d.st = SCC_ST_RUN; // [R10] [R18]
               start_ev = 1'b1;
            end
         end
         SCC_ST_RUN: begin
         end
         default: d.st = SCC_ST_XO;
      endcase
      if (pll_active(q.st) &&
          (!q.ctrl[CTRL_PLL] || q.ctrl[CTRL_SLEEP])) begin
         d.st = SCC_ST_IDLE;
      end
      d.ana.frf = q.frf; // [R1] [R2] word counts steps of crystal/2^19
      d.ana.vco_mult = band_mult(q.ctrl[CTRL_BAND+:2]); // [R15]
      d.ana.pll_en = pll_active(d.st); // [R4] [R14]
      d.ana.rx_en = d.st == SCC_ST_RUN && !q.ctrl[CTRL_TX]; // [R10]
      d.ana.tx_en = d.st == SCC_ST_RUN && q.ctrl[CTRL_TX];

      // ************************************************************
      // reference clock out on gpio five
      // ************************************************************
      d.div = q.div + 7'd1;
      if (!q.xo_ok || q.ctrl[CTRL_SLEEP] ||
          q.map2[2:0] == CLKSEL_OFF) begin
         d.clk_o = 1'b0; // [R5] [R8]
      end else begin
         d.clk_o = div_tap(q.div, q.map2[2:0], q.clk_o); // [R7] [R17]
      end

      // ************************************************************
      // lock indication and events
      // ************************************************************
      // lock indicator routed to one selected pin
      d.lock_pins = 4'h0;
      d.lock_pins[q.map2[MAP_LOCK+:2]] = q.lk_ok; // [R12]

      // sticky events, set wins over clear
      d.irq_stat = (q.irq_stat & ~clr) |
                   {start_ev, unlock_ev, lock_ev, xo_rise_ev}; // [R12]
      d.irq = |(d.irq_stat & q.irq_en);
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.frf <= FRF_RST;
         q.ctrl <= CTRL_RST;
         q.map2 <= PIN_MAP2_RST;
         q.irq_stat <= IRQ_RST;
         q.st <= SCC_ST_XO;
         q.ana.vco_mult <= 3'd2;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign prdata = q.rdata;
   assign pready = q.ready;
   assign pslverr = q.err;
   assign ana_out = q.ana;
   assign gpio_five = q.clk_o;
   assign gpio_lock = q.lock_pins;
   assign pll_lock_indicator = q.lk_ok;
   assign irq = q.irq;
endmodule
`default_nettype wire

/* File: tb/scc_checker.sv */
/* port checker for the synthesis clock control block.
   assumes the port names of scc_synth_ctrl; bound to each instance. */
`timescale 1ns/1ps
`default_nettype none
module scc_checker
   import scc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire scc_pkg::scc_ana_in_t ana_in,
   input wire scc_pkg::scc_ana_out_t ana_out,
   input wire logic gpio_five,
   input wire logic [3:0] gpio_lock,
   input wire logic pll_lock_indicator,
   input wire logic irq
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence wr_done;
      psel && penable && pready && pwrite;
   endsequence
   sequence lsb_wr;
      wr_done ##0 (paddr == 12'h024);
   endsequence
   sequence hi_wr;
      wr_done ##0 (paddr == 12'h01C || paddr == 12'h020);
   endsequence
   frf_stage_a: assert property (hi_wr |=> $stable(ana_out.frf))
      else $error("staged byte moved carrier");
   frf_commit_a:
      assert property (lsb_wr |=> ##1 ana_out.frf[7:0] == $past(pwdata[7:0], 2))
      else $error("carrier low byte not committed");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   apb_stand_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   xo_quiet_a: assert property (!ana_in.xo_stable [*6] |-> !gpio_five)
      else $error("clock out before crystal");
   lock_show_a:
      assert property (ana_in.lock [*6] |-> pll_lock_indicator)
      else $error("lock not shown");
   lock_drop_a:
      assert property (!ana_in.lock [*6] |-> !pll_lock_indicator)
      else $error("unlock not shown");
   pll_start_a:
      assert property ($rose(ana_out.pll_en) |-> ana_in.xo_stable)
      else $error("pll before crystal");
   path_start_a:
      assert property ($rose(ana_out.rx_en || ana_out.tx_en)
         |-> pll_lock_indicator)
      else $error("path before lock");
   vco_mult_a: assert property (ana_out.vco_mult inside {3'h2, 3'h4, 3'h6})
      else $error("bad vco multiplier");
endmodule
bind scc_synth_ctrl scc_checker u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ana_in, .ana_out,
   .gpio_five, .gpio_lock, .pll_lock_indicator, .irq);
`default_nettype wire

/* File: tb/scc_ana_model.sv */
/* analog stand-in: crystal settles after a delay, pll locks after enable.
   assumes the bench pulses drop to mimic unlock under wide deviation. */
`timescale 1ns/1ps
`default_nettype none
module scc_ana_model
   import scc_pkg::*;
#(
   parameter int XO_DLY = 40,
   parameter int LOCK_DLY = 30
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pll_en,
   input wire logic drop,
   output scc_pkg::scc_ana_in_t ana
);
   int xo_q;
   int lk_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xo_q <= 0;
         lk_q <= 0;
      end else begin
         if (xo_q < XO_DLY)
            xo_q <= xo_q + 1;
         if (!pll_en || drop)
            lk_q <= 0;
         else if (lk_q < LOCK_DLY)
            lk_q <= lk_q + 1;
      end
   end
   assign ana.xo_stable = (xo_q == XO_DLY);
   assign ana.lock = (lk_q == LOCK_DLY);
endmodule
`default_nettype wire

/* File: tb/scc_synth_ctrl_test.sv */
/* self-checking bench for scc_synth_ctrl over apb.
   assumes scc_ana_model on the analog side and scc_checker bound. */
`timescale 1ns/1ps
`default_nettype none
module scc_synth_ctrl_test;
   import scc_pkg::*;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic drop = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, r;
   logic pready, pslverr, gpio_five, pll_lock_indicator, irq, e;
   logic [3:0] gpio_lock;
   scc_ana_in_t ana_in;
   scc_ana_out_t ana_out;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int k;
   always #10 pclk = ~pclk;
   scc_synth_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ana_in, .ana_out, .gpio_five,
      .gpio_lock, .pll_lock_indicator, .irq);
   scc_ana_model MDL (.pclk, .presetn, .pll_en(ana_out.pll_en), .drop,
      .ana(ana_in));
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         errors++;
         $display("ERROR %0t seen %h want %h", $time, s, x);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      acc(1'b0, a, 32'h0000_0000);
      chk(r, x);
   endtask
   task automatic wait_state(input logic [2:0] s);
      int n;
      n = 0;
      do begin
         acc(1'b0, 12'h104, 32'h0000_0000);
         n++;
      end while (r[2:0] !== s && n < 400);
      chk({29'h0, r[2:0]}, {29'h0, s});
   endtask
   // counts rising edges of the clock output pin
   task automatic cnt(input int len);
      logic p;
      k = 0;
      p = gpio_five;
      repeat (len) begin
         @(posedge pclk);
         if (gpio_five && !p)
            k++;
         p = gpio_five;
      end
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         report_and_stop;
      end
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h100, 32'h0000_0001);
      rd(12'h098, 32'h0000_0000);
      acc(1'b0, 12'h200, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
      acc(1'b1, 12'h01C, 32'h0000_00AB);
      acc(1'b1, 12'h020, 32'h0000_00CD);
      chk({8'h00, ana_out.frf}, 32'h0000_0000);
      rd(12'h01C, 32'h0000_00AB);
      acc(1'b1, 12'h024, 32'h0000_00EF);
      @(posedge pclk);
      chk({8'h00, ana_out.frf}, 32'h00AB_CDEF);
      rd(12'h114, 32'h00AB_CDEF);
      wait_state(SCC_ST_IDLE);
      rd(12'h104, 32'h0000_0012);
      for (int s = 0; s < 4; s++) begin
         acc(1'b1, 12'h098, 32'(s));
         repeat (32) @(posedge pclk);
         cnt(16 << s);
         chk(k, 32'h0000_0008);
      end
      acc(1'b1, 12'h098, 32'h0000_0007);
      cnt(64);
      chk(k, 32'h0000_0000);
      acc(1'b1, 12'h098, 32'h0000_0020);
      acc(1'b1, 12'h10C, 32'h0000_000F);
      acc(1'b1, 12'h100, 32'h0000_0013);
      wait_state(SCC_ST_RUN);
      chk({31'h0, pll_lock_indicator}, 32'h0000_0001);
      chk({27'h0, ana_out.rx_en, ana_out.tx_en, ana_out.vco_mult},
         32'h0000_0014);
      chk({28'h0, gpio_lock}, 32'h0000_0004);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(12'h108, 32'h0000_000B);
      acc(1'b1, 12'h110, 32'h0000_000F);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0000);
      drop <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({31'h0, pll_lock_indicator}, 32'h0000_0000);
      rd(12'h108, 32'h0000_0004);
      drop <= 1'b0;
      for (int b = 0; b < 3; b++) begin
         acc(1'b1, 12'h100, 32'(3 + 16 * b));
         repeat (2) @(posedge pclk);
         chk({29'h0, ana_out.vco_mult}, 32'(2 + 2 * b));
      end
      acc(1'b1, 12'h100, 32'h0000_000B);
      repeat (8) @(posedge pclk);
      cnt(32);
      chk(k, 32'h0000_0000);
      report_and_stop;
   end
endmodule
`default_nettype wire
